//--- dv/smsr_cmdr.sv
`timescale 1ns/1ps

module smsr_cmdr (
  output logic spi_sclk_out,
  output logic spi_cs_n_out,
  output logic spi_si_out,
  input wire logic spi_so_in,
  output logic [31:0] rx_word_out,
  output logic done_out
);
  // ----
  // Commander: 125 ns clock, slow mode stretches the low phase
  // ----
  initial begin
    spi_sclk_out = 1'h0;
    spi_cs_n_out = 1'h1;
    spi_si_out = 1'h0;
    rx_word_out = 32'h00000000;
    done_out = 1'h0;
  end

  task automatic xfer(input logic [31:0] w, input int n, input logic slow);
    logic [31:0] r;
    r = 32'h00000000;
    #2;
    spi_cs_n_out = 1'h0;
    #150;
    for (int i = 0; i < n; i++) begin
      spi_si_out = w[31 - (i % 32)];
      #31;
      spi_sclk_out = 1'h1;
      #62.5;
      spi_sclk_out = 1'h0;
      r = {r[30:0], spi_so_in};
      #(slow ? 531.5 : 31.5);
    end
    #100;
    spi_cs_n_out = 1'h1;
    spi_si_out = ~spi_si_out;
    rx_word_out = r;
    if (n == 32) done_out = ~done_out;
    #300;
  endtask

  // Deliberate clock and data activity while deselected
  task automatic noise();
    repeat (4) begin
      #62.5;
      spi_sclk_out = 1'h1;
      spi_si_out = ~spi_si_out;
      #62.5;
      spi_sclk_out = 1'h0;
    end
  endtask
endmodule

//--- dv/smsr_responder_sva.sv
`timescale 1ns/1ps

module smsr_responder_sva (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_so_out,
  input wire logic spi_so_oe_n_out,
  input wire logic int_n_out,
  input wire logic soft_reset_event_in,
  input wire logic switch_change_event_in,
  input wire logic [23:0] event_status_out
);
  // ----
  // Link and event checks
  // ----
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence cs_idle;
    spi_cs_n_in [*5];
  endsequence
  // Sclk low on two samples cannot hide a rise: its high phase is far longer than a cycle
  sequence link_quiet;
    !spi_cs_n_in && !spi_sclk_in && !$past(spi_cs_n_in) && !$past(spi_sclk_in);
  endsequence
  sequence evt_cleared;
    (event_status_out != 24'h000000) ##1 (event_status_out == 24'h000000);
  endsequence

  AST_OE_ON: assert property ($fell(spi_cs_n_in) |-> ##[1:4] !spi_so_oe_n_out)
    else $error("output not enabled after select");
  AST_OE_OFF: assert property ($rose(spi_cs_n_in) |-> ##[1:4] spi_so_oe_n_out)
    else $error("output not released after deselect");
  AST_INT_RELEASE: assert property ($rose(int_n_out) |->
    spi_cs_n_in && event_status_out == 24'h000000)
    else $error("interrupt released with events pending");
  AST_SO_STABLE: assert property (link_quiet |-> $stable(spi_so_out))
    else $error("serial output moved without a clock rise");
  AST_IDLE_OFF: assert property (cs_idle |-> spi_so_oe_n_out)
    else $error("output driven while deselected");
  AST_INT_ASSERT: assert property ($rose(|event_status_out) |=> !int_n_out)
    else $error("interrupt not raised for a new event");
  AST_SO_HIGH: assert property ($fell(spi_so_oe_n_out) |-> spi_so_out)
    else $error("serial output not high at enable");
  AST_EV_SSC: assert property (switch_change_event_in |-> ##[1:2] event_status_out[3])
    else $error("switch change not recorded");
  AST_EVT_CLEAR: assert property (evt_cleared |-> spi_cs_n_in && $past(spi_cs_n_in))
    else $error("event status cleared inside a frame");
  AST_EV_RESET: assert property (soft_reset_event_in |-> ##[1:2] event_status_out[0])
    else $error("reset event not recorded");
endmodule

bind smsr_responder smsr_responder_sva smsr_responder_sva_i (.core_clk_in, .nrst_in,
  .spi_sclk_in, .spi_cs_n_in, .spi_so_out, .spi_so_oe_n_out, .int_n_out,
  .soft_reset_event_in, .switch_change_event_in, .event_status_out);

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "smsr_consts.svh"

module testbench;
  // ----
  // Bench state
  // ----
  localparam logic [23:0] DEVV = 24'h2B61C4;  // Arbitrary identity value
  localparam logic [23:0] TESTV = 24'h15A5A5;
  logic core_clk_in, nrst_in, sclk, cs_n, si, so, so_w, oe_n, int_n_out, done;
  logic [7:0] ev;
  logic [23:0] crc, misc, comp, evt, event_status_out;
  logic [263:0] cfgm, cfg_flat_out;
  logic [31:0] rx;
  logic [31:0] expq[$];
  int n_fail = 0;
  int n_compared = 0;
  int pos[8] = '{0, 3, 5, 4, 6, 7, 8, 13};
  logic [5:0] ro[8] = '{6'h01, 6'h03, 6'h04, 6'h05, 6'h3C, 6'h3D, 6'h10, 6'h30};

  // Released output line shows the inverse, so a late enable garbles data
  assign so_w = oe_n ? ~so : so;

  smsr_responder #(.NUM_CFG(11), .DEV_ID(DEVV), .TEST_VAL(TESTV)) smsr_responder_i (
    .core_clk_in, .nrst_in, .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_si_in(si),
    .spi_so_out(so), .spi_so_oe_n_out(oe_n), .int_n_out, .soft_reset_event_in(ev[0]),
    .switch_change_event_in(ev[1]), .temperature_warning_event_in(ev[2]),
    .thermal_shutdown_event_in(ev[3]), .overvoltage_event_in(ev[4]),
    .undervoltage_event_in(ev[5]), .checksum_done_event_in(ev[6]),
    .factory_load_error_event_in(ev[7]), .crc_result_in(crc), .misc_status_in(misc),
    .comp_status_in(comp), .cfg_flat_out, .event_status_out);

  smsr_cmdr smsr_cmdr_i (.spi_sclk_out(sclk), .spi_cs_n_out(cs_n), .spi_si_out(si),
    .spi_so_in(so_w), .rx_word_out(rx), .done_out(done));

  initial begin
    core_clk_in = 1'h0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [263:0] seen, input logic [263:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] exp_out(input logic [23:0] d);
    logic [31:0] w;
    w = {1'h0, evt[0], evt[1], evt[2], evt[3], 1'h0, evt[4] | evt[5],
         |{evt[6], evt[7], evt[8], evt[13]}, 1'h0, d[21:0], 1'h0};
    w[0] = ~^w[31:1];
    return w;
  endfunction

  function automatic logic [23:0] regval(input logic [5:0] a);
    if (a == `SMSR_ADDR_EVT) return evt;
    if (a == `SMSR_ADDR_ID) return DEVV;
    if (a == `SMSR_ADDR_CRC) return crc;
    if (a == `SMSR_ADDR_MISC) return misc;
    if (a == `SMSR_ADDR_COMP) return comp;
    if (a >= 6'h1A && a <= 6'h24) return cfgm[(int'(a) - 26) * 24 +: 24];
    if (a >= 6'h3C) return TESTV;
    return 24'h000000;
  endfunction

  // Driver notes the expected reply, then runs the frame and checks side effects
  task automatic acc(input logic rw, input logic [5:0] a, input logic [23:0] d, input int n,
                     input logic bad, input logic slow);
    logic [31:0] w;
    w = {rw, a, d, 1'h0};
    w[0] = ~^w[31:1] ^ bad;
    if (n == 32) expq.push_back(exp_out(regval(a)));
    smsr_cmdr_i.xfer(w, n, slow);
    if (n != 0 && n != 32) evt[1] = 1'h1;
    else if (n == 32 && bad) evt[2] = 1'h1;
    else if (n == 32 && !rw && a == `SMSR_ADDR_EVT) evt = 24'h000000;
    else if (n == 32 && rw && a >= 6'h1A && a <= 6'h24) cfgm[(int'(a) - 26) * 24 +: 24] = d;
    check(event_status_out, evt);
    check(int_n_out, ~|evt);
    check(cfg_flat_out, cfgm);
  endtask

  // Waits for reset so the port's first value at time zero is not taken for a frame
  initial begin
    @(posedge nrst_in);
    forever begin
      @(done);
      #1;
      check(rx, expq.pop_front());
    end
  end

  initial begin
    #600000;
    n_fail++;
    summarize();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(32'hA23C4899));
    nrst_in = 1'h0;
    ev = 8'h00;
    crc = 24'h000000;
    misc = 24'h000000;
    comp = 24'h000000;
    evt = 24'h000001;
    cfgm = '0;
    repeat (8) @(posedge core_clk_in);
    nrst_in <= 1'h1;
    crc <= 24'($urandom);
    misc <= 24'($urandom);
    comp <= 24'($urandom);
    repeat (3) @(posedge core_clk_in);
    check(event_status_out, 24'h000001);
    check(int_n_out, 1'h0);
    acc(1'h0, `SMSR_ADDR_EVT, 24'($urandom), 32, 1'h0, 1'h0);
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      for (int a = 26; a <= 36; a++) acc(p < 2, 6'(a), 24'($urandom), 32, 1'h0, p == 1);
    end
    $display("test config done");
    foreach (ro[i]) acc(i % 2 == 1, ro[i], 24'($urandom), 32, 1'h0, 1'h0);
    $display("test readonly done");
    acc(1'h1, 6'h1B, 24'($urandom), 31, 1'h0, 1'h0);
    acc(1'h1, 6'h1B, 24'($urandom), 33, 1'h0, 1'h0);
    acc(1'h1, 6'h1C, 24'($urandom), 0, 1'h0, 1'h0);
    acc(1'h1, 6'h1D, 24'($urandom), 32, 1'h1, 1'h0);
    acc(1'h0, `SMSR_ADDR_EVT, 24'($urandom), 32, 1'h0, 1'h0);
    smsr_cmdr_i.noise();
    check(event_status_out, evt);
    $display("test errors done");
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk_in);
      ev <= 8'(1 << k);
      @(posedge core_clk_in);
      ev <= 8'h00;
      evt[pos[k]] = 1'h1;
      repeat (3) @(posedge core_clk_in);
      check(int_n_out, 1'h0);
      acc(1'h0, `SMSR_ADDR_EVT, 24'($urandom), 32, 1'h0, 1'h0);
    end
    $display("test events done");
    check(expq.size(), 0);
    summarize();
  end
endmodule

//--- shared/smsr_consts.svh
`ifndef SMSR_CONSTS_SVH
`define SMSR_CONSTS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SMSR_FRAME_BITS 6'h20
`define SMSR_CNT_MAX 6'h21
`define SMSR_ADDR_LAST_EDGE 6'h06
`define SMSR_RW_BIT 31
`define SMSR_ADDR_HI 30
`define SMSR_ADDR_LO 25
`define SMSR_PAY_HI 24
`define SMSR_PAY_LO 1
`define SMSR_DATA_W 24
`define SMSR_OUT_DATA_W 22

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SMSR_ADDR_ID 6'h01
`define SMSR_ADDR_EVT 6'h02
`define SMSR_ADDR_CRC 6'h03
`define SMSR_ADDR_MISC 6'h04
`define SMSR_ADDR_COMP 6'h05
`define SMSR_ADDR_CFG_FIRST 6'h1A
`define SMSR_ADDR_CFG_LAST 6'h24
`define SMSR_ADDR_TEST_FIRST 6'h3C
`define SMSR_ADDR_TEST_LAST 6'h3F

// ----------------------------------------
// Event status bit positions and register reset values
// ----------------------------------------
`define SMSR_EV_RESET 0
`define SMSR_EV_LEN 1
`define SMSR_EV_PAR 2
`define SMSR_EV_SSC 3
`define SMSR_EV_TSD 4
`define SMSR_EV_TW 5
`define SMSR_EV_OV 6
`define SMSR_EV_UV 7
`define SMSR_EV_CRC 8
`define SMSR_EV_CHK 13
`define SMSR_EVT_RESET_VAL 24'h000001
`define SMSR_CFG_RESET_VAL 24'h000000

`endif

//--- shared/smsr_pkg.sv
package smsr_pkg;

  // Frame tracking in the core domain
  typedef enum logic [2:0] {
    SMSR_ST_IDLE = 3'b001,
    SMSR_ST_HEAD = 3'b010,
    SMSR_ST_BODY = 3'b100
  } smsr_state_t;

endpackage

//--- src/smsr_responder.sv
//
// Contract
// - Chip select falling enables the data output and snapshots event status.
// - Chip select rising disables the data output driver.
// - Interrupt released at chip select rising after an event status read.
// - Sample input on falling clock edges, shift output on rising edges.
// - With chip select high, clock and input are ignored, output off.
// - Exactly 32 clocks accepted; other nonzero counts discard, flag length error, interrupt.
// - Output high after select; first rising edge shows bit 31, then downward.
// - Inbound and outbound words travel most significant bit first.
// - Payload bits of a read frame are ignored.
// - Outbound frame carries flags, then register data, then parity.
// - Hidden test registers return content; writes leave them unchanged.
// - Undefined addresses return all zeros.
// - Writes to non-writable addresses are ignored.
// - Write frames return the old value captured once the address lands.
// - Write commits at frame end only if address valid and error free.
// - Flags mirror event status; reading event status clears both.
// - Event status clear takes effect at chip select rising.
// - Odd parity over 32 bits; even count discards, flags, interrupts.
// - Thermal flag is OR of temperature warning and shutdown events.
// - Misc flag is OR of voltage, checksum-done and load-error events.
// - Reserved flag always reads zero.
// - Reset flag copies reset event, set by any reset.
// - Event status at address 2h, resets to 1h.
`timescale 1ns/1ps
`include "smsr_consts.svh"

module smsr_responder
  import smsr_pkg::*;
#(
  parameter int NUM_CFG = 11,
  parameter logic [23:0] DEV_ID = 24'h000ABC,
  parameter logic [23:0] TEST_VAL = 24'h000000
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_si_in,
  output logic spi_so_out,
  output logic spi_so_oe_n_out,
  output logic int_n_out,
  input wire logic soft_reset_event_in,
  input wire logic switch_change_event_in,
  input wire logic temperature_warning_event_in,
  input wire logic thermal_shutdown_event_in,
  input wire logic overvoltage_event_in,
  input wire logic undervoltage_event_in,
  input wire logic checksum_done_event_in,
  input wire logic factory_load_error_event_in,
  input wire logic [23:0] crc_result_in,
  input wire logic [23:0] misc_status_in,
  input wire logic [23:0] comp_status_in,
  output logic [NUM_CFG*24-1:0] cfg_flat_out,
  output logic [23:0] event_status_out
);

  localparam int IDX_W = $clog2(NUM_CFG);

  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  function automatic logic is_cfg(input logic [5:0] addr);
    is_cfg = (addr >= `SMSR_ADDR_CFG_FIRST) && (addr <= `SMSR_ADDR_CFG_LAST);
  endfunction

  function automatic logic is_test(input logic [5:0] addr);
    is_test = (addr >= `SMSR_ADDR_TEST_FIRST) && (addr <= `SMSR_ADDR_TEST_LAST);
  endfunction

  function automatic logic [IDX_W-1:0] cfg_index(input logic [5:0] addr);
    logic [5:0] diff;
    diff = addr - `SMSR_ADDR_CFG_FIRST;
    cfg_index = diff[IDX_W-1:0];
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  smsr_state_t state_reg;
  smsr_state_t state_next;
  logic clr_reg;
  logic oe_n_reg;
  logic int_n_reg;
  logic [23:0] evt_reg;
  logic [23:0] evt_next;
  logic [23:0] evt_set;
  logic [31:1] tx_body_reg;
  logic [31:1] tx_body_next;
  logic [31:0] tx_word;
  logic [23:0] cfg_arr [NUM_CFG];

  logic [5:0] rx_cnt_reg;
  logic [31:0] rx_word_reg;
  logic [5:0] addr_hold_reg;
  logic addr_done_reg;
  logic so_reg;
  logic [5:0] rx_cnt_next;
  logic [31:0] rx_word_next;
  logic at_addr_edge;
  logic so_next;

  logic [1:0] sync_d;
  logic [1:0] sync_q;
  logic cs_high_sync;
  logic addr_seen_sync;

  // ----------------------------------------
  // Crossings into the core domain
  // ----------------------------------------
  // Chip select only reaches logic through the synchroniser; the link side
  // is held idle by clr_reg, which follows chip select two to three cycles late.
  assign sync_d = {addr_done_reg, spi_cs_n_in};

  smsr_sync #(
    .WIDTH(2),
    .RST_VAL(2'h1)
  ) u_sync (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .d_in(sync_d),
    .q_out(sync_q)
  );

  assign cs_high_sync = sync_q[0];
  assign addr_seen_sync = sync_q[1];

  // ----------------------------------------
  // Link domain: receive on falling edges
  // ----------------------------------------
  // Saturating count: anything above 32 is a length error anyway.
  assign rx_cnt_next = (rx_cnt_reg == `SMSR_CNT_MAX) ? rx_cnt_reg :
                       rx_cnt_reg + 6'h01;
  assign rx_word_next = {rx_word_reg[30:0], spi_si_in};
  assign at_addr_edge = (rx_cnt_reg == `SMSR_ADDR_LAST_EDGE);

  // clr_reg follows chip select high two to three cycles late, so edges are then ignored
  always_ff @(negedge spi_sclk_in or posedge clr_reg) begin
    if (clr_reg) begin
      rx_cnt_reg <= 6'h00;
      rx_word_reg <= 32'h00000000;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      rx_word_reg <= rx_word_next;
    end
  end

  // Address is held still here so the core can read it across domains
  always_ff @(negedge spi_sclk_in or posedge clr_reg) begin
    if (clr_reg) begin
      addr_hold_reg <= 6'h00;
      addr_done_reg <= 1'b0;
    end else if (at_addr_edge) begin
      addr_hold_reg <= {rx_word_reg[4:0], spi_si_in};
      addr_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Link domain: transmit on rising edges
  // ----------------------------------------
  // Rising edge k shows bit 32-k; past the word the line stays low.
  assign tx_word = {tx_body_reg, ~^tx_body_reg};
  assign so_next = rx_cnt_reg[5] ? 1'b0 : tx_word[~rx_cnt_reg[4:0]];

  always_ff @(posedge spi_sclk_in or posedge clr_reg) begin
    if (clr_reg) begin
      so_reg <= 1'b1;
    end else begin
      so_reg <= so_next;
    end
  end

  assign spi_so_out = so_reg;

  // ----------------------------------------
  // Frame end decode
  // ----------------------------------------
  // At frame end the link clock stands still, so the receive state is
  // stable until clr_reg rises one cycle later.
  logic frame_end;
  logic rx_none;
  logic rx_len_ok;
  logic rx_par_ok;
  logic len_err;
  logic par_err;
  logic frame_ok;
  logic rx_write;
  logic [5:0] rx_addr;
  logic evt_clear;
  logic wr_ok;
  logic [IDX_W-1:0] wr_idx;

  assign frame_end = (state_reg != SMSR_ST_IDLE) && cs_high_sync;
  assign rx_none = (rx_cnt_reg == 6'h00);
  assign rx_len_ok = (rx_cnt_reg == `SMSR_FRAME_BITS);
  assign rx_par_ok = ^rx_word_reg;
  assign len_err = frame_end && !rx_none && !rx_len_ok;
  assign par_err = frame_end && rx_len_ok && !rx_par_ok;
  assign frame_ok = frame_end && rx_len_ok && rx_par_ok;
  assign rx_write = rx_word_reg[`SMSR_RW_BIT];
  assign rx_addr = rx_word_reg[`SMSR_ADDR_HI:`SMSR_ADDR_LO];
  assign evt_clear = frame_ok && !rx_write && (rx_addr == `SMSR_ADDR_EVT);
  assign wr_ok = frame_ok && rx_write && is_cfg(rx_addr);
  assign wr_idx = cfg_index(rx_addr);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
      logic [23:0] val_reg;
      logic hit;
      assign hit = wr_ok && (wr_idx == IDX_W'(gi));
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          val_reg <= `SMSR_CFG_RESET_VAL;
        end else if (hit) begin
          val_reg <= rx_word_reg[`SMSR_PAY_HI:`SMSR_PAY_LO];
        end
      end
      assign cfg_arr[gi] = val_reg;
      assign cfg_flat_out[gi*24 +: 24] = val_reg;
    end
  endgenerate

  // ----------------------------------------
  // Event status
  // ----------------------------------------
  always_comb begin
    evt_set = 24'h000000;
    evt_set[`SMSR_EV_RESET] = soft_reset_event_in;
    evt_set[`SMSR_EV_LEN] = len_err;
    evt_set[`SMSR_EV_PAR] = par_err;
    evt_set[`SMSR_EV_SSC] = switch_change_event_in;
    evt_set[`SMSR_EV_TSD] = thermal_shutdown_event_in;
    evt_set[`SMSR_EV_TW] = temperature_warning_event_in;
    evt_set[`SMSR_EV_OV] = overvoltage_event_in;
    evt_set[`SMSR_EV_UV] = undervoltage_event_in;
    evt_set[`SMSR_EV_CRC] = checksum_done_event_in;
    evt_set[`SMSR_EV_CHK] = factory_load_error_event_in;
  end

  // A new event in the clearing cycle survives the clear
  assign evt_next = (evt_clear ? 24'h000000 : evt_reg) | evt_set;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      evt_reg <= `SMSR_EVT_RESET_VAL;
      int_n_reg <= 1'b0;
    end else begin
      evt_reg <= evt_next;
      int_n_reg <= ~|evt_next;
    end
  end

  assign int_n_out = int_n_reg;
  assign event_status_out = evt_reg;

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic flag_reset;
  logic flag_len;
  logic flag_par;
  logic switch_change_flag;
  logic reserved_flag;
  logic thermal_flag;
  logic misc_event_flag;
  logic [6:0] flags;

  assign flag_reset = evt_reg[`SMSR_EV_RESET];
  assign flag_len = evt_reg[`SMSR_EV_LEN];
  assign flag_par = evt_reg[`SMSR_EV_PAR];
  assign switch_change_flag = evt_reg[`SMSR_EV_SSC];
  assign reserved_flag = 1'b0;
  assign thermal_flag = evt_reg[`SMSR_EV_TW] | evt_reg[`SMSR_EV_TSD];
  assign misc_event_flag = evt_reg[`SMSR_EV_OV] | evt_reg[`SMSR_EV_UV] |
                           evt_reg[`SMSR_EV_CRC] | evt_reg[`SMSR_EV_CHK];
  assign flags = {flag_reset, flag_len, flag_par, switch_change_flag,
                  reserved_flag, thermal_flag, misc_event_flag};

  // ----------------------------------------
  // Read selection
  // ----------------------------------------
  logic [23:0] rd_data;
  logic [23:0] rd_fixed;
  logic [5:0] rd_addr;

  assign rd_addr = addr_hold_reg;

  always_comb begin
    case (rd_addr)
      `SMSR_ADDR_ID: rd_fixed = DEV_ID;
      `SMSR_ADDR_EVT: rd_fixed = evt_reg;
      `SMSR_ADDR_CRC: rd_fixed = crc_result_in;
      `SMSR_ADDR_MISC: rd_fixed = misc_status_in;
      `SMSR_ADDR_COMP: rd_fixed = comp_status_in;
      default: rd_fixed = 24'h000000;
    endcase
  end

  // Test registers answer reads and writes alike and are never written
  assign rd_data = is_cfg(rd_addr) ? cfg_arr[cfg_index(rd_addr)] :
                   is_test(rd_addr) ? TEST_VAL : rd_fixed;

  // ----------------------------------------
  // Frame tracking and outbound word
  // ----------------------------------------
  // Limitation: the driver turns on two to three core cycles after chip
  // select falls; the first bit is not sampled before the second edge.
  always_comb begin
    state_next = state_reg;
    tx_body_next = tx_body_reg;
    case (state_reg)
      SMSR_ST_IDLE: begin
        if (!cs_high_sync) begin
          state_next = SMSR_ST_HEAD;
          tx_body_next = {1'b0, flags, 1'b0, 22'h000000};
        end
      end
      SMSR_ST_HEAD: begin
        if (cs_high_sync) begin
          state_next = SMSR_ST_IDLE;
        end else if (addr_seen_sync) begin
          state_next = SMSR_ST_BODY;
          tx_body_next = {tx_body_reg[31:23],
                          rd_data[`SMSR_OUT_DATA_W-1:0]};
        end
      end
      SMSR_ST_BODY: begin
        if (cs_high_sync) begin
          state_next = SMSR_ST_IDLE;
        end
      end
      default: begin
        state_next = SMSR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= SMSR_ST_IDLE;
      tx_body_reg <= 31'h00000000;
    end else begin
      state_reg <= state_next;
      tx_body_reg <= tx_body_next;
    end
  end

  // ----------------------------------------
  // Link hold-off and output enable
  // ----------------------------------------
  // clr_reg also resets the link logic after power-up, while the link
  // clock may still be stopped.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clr_reg <= 1'b1;
      oe_n_reg <= 1'b1;
    end else begin
      clr_reg <= cs_high_sync;
      oe_n_reg <= cs_high_sync;
    end
  end

  assign spi_so_oe_n_out = oe_n_reg;

endmodule

//--- src/smsr_sync.sv
`timescale 1ns/1ps

// Two-flop level synchroniser, one stage pair per bit
module smsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end

endmodule
